// ### rtl/ebpm_pkg.sv
// Package for the external bus pin ownership mux.
// Assumes one system clock domain; offsets are byte addresses.
package ebpm_pkg;
  // Register map
  localparam logic [7:0]  REG_OWNERSHIP_ADDR = 8'h00; // Pin ownership reg
  localparam logic [7:0]  REG_STATUS_ADDR    = 8'h04; // Effective owners
  localparam logic [31:0] OWNERSHIP_RESET    = 32'h0000_0000;
  // Field positions
  localparam int OE_BIT    = 12; // Output enable claim
  localparam int BS1_BIT   = 9;  // Byte select 1 claim
  localparam int BS0_BIT   = 8;  // Byte select 0 claim
  localparam int CS_HI_BIT = 7;  // Chip select 3 claim
  localparam int CS_LO_BIT = 4;  // Chip select 0 claim
  localparam int UPD_BIT   = 1;  // Upper data lane claim
  localparam int LOD_BIT   = 0;  // Lower data lane claim
  // Writable bits; 11:10 and 3:2 stay zero
  localparam logic [31:0] OWNERSHIP_MASK = 32'h0000_13F3;
  // Data lane width
  localparam int LANE_W = 8;
endpackage

// ### rtl/ebpm_pad_mux.sv
// Per-pin mux between bus controller and general I/O drive.
// Assumes the select arrives from a flip-flop on the same clock.
`timescale 1ns/1ps
module ebpm_pad_mux #(
  parameter int W = 1 // Pins in this group
) (
  input  wire logic         clk,      // System clock
  input  wire logic         rst_n,    // Sync reset, active low
  input  wire logic         sel_bus,  // Bus owns pins
  input  wire logic [W-1:0] bus_out,  // Bus drive value
  input  wire logic [W-1:0] bus_oe_n, // Bus enable, low drives
  input  wire logic [W-1:0] gp_out,   // General I/O value
  input  wire logic [W-1:0] gp_oe_n,  // General enable, low drives
  output logic      [W-1:0] pad_out,  // Pad drive value
  output logic      [W-1:0] pad_oe_n  // Pad enable, low drives
);
  // Registered pad drive avoids glitches from the combinational select
  typedef struct packed {
    logic [W-1:0] out_ff;
    logic [W-1:0] oe_n_ff;
  } ebpm_mux_st_t;
  ebpm_mux_st_t st_ff;
  ebpm_mux_st_t nxt_st;

  // Choose owner
  always_comb
  begin
    nxt_st = st_ff;
    if (!rst_n)
    begin
      nxt_st.out_ff  = '0;
      nxt_st.oe_n_ff = '1; // Pads float at reset
    end
    else if (sel_bus)
    begin
      nxt_st.out_ff  = bus_out;
      nxt_st.oe_n_ff = bus_oe_n;
    end
    else
    begin
      nxt_st.out_ff  = gp_out;
      nxt_st.oe_n_ff = gp_oe_n;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    st_ff <= nxt_st; // [RULE_09]
  end

  assign pad_out  = st_ff.out_ff;
  assign pad_oe_n = st_ff.oe_n_ff;
endmodule

// ### rtl/ebpm_top.sv
// Pin ownership logic for the external memory bus pins.
// Assumes reg port on clk; bus_module_disable is an async pin input.
// Overview of operation
// RULE_01: Bit 12 gives output enable pin
// RULE_02: Bit 9 gives byte select 1 pin
// RULE_03: Bit 8 gives byte select 0 pin
// RULE_04: Bits 7..4 give chip selects 3..0
// RULE_05: Bit 1 gives upper data lane
// RULE_06: Bit 0 gives lower data lane
// RULE_07: Module disable returns all pins
// RULE_08: Bits 11:10, 3:2 read zero
// RULE_09: Ownership switches next edge, glitch free; here the pads follow the ownership register two edges later
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module ebpm_top
  import ebpm_pkg::*;
(
  input  wire logic        clk,          // System clock
  input  wire logic        rst_n,        // Sync reset, active low
  input  wire logic [7:0]  reg_addr,     // Register address
  input  wire logic [31:0] reg_wdata,    // Write data
  input  wire logic        reg_wr,       // Write strobe
  input  wire logic        reg_rd,       // Read strobe
  output logic      [31:0] reg_rdata,    // Read data, next cycle
  input  wire logic        bus_module_disable, // Pin, high disables
  input  wire logic [9:0]  bus_ctl_out,  // Bus ctl pin values
  input  wire logic [9:0]  gp_ctl_out,   // GPIO ctl pin values
  input  wire logic [9:0]  gp_ctl_oe_n,  // GPIO ctl enables
  output logic      [9:0]  ctl_pad_out,  // Ctl pad values
  output logic      [9:0]  ctl_pad_oe_n, // Ctl pad enables
  input  wire logic [15:0] bus_data_out, // Bus data drive
  input  wire logic        bus_data_oe_n,// Bus data enable
  input  wire logic [15:0] gp_data_out,  // GPIO data drive
  input  wire logic [15:0] gp_data_oe_n, // GPIO data enables
  input  wire logic [15:0] data_pad_in,  // Data pad level
  output logic      [15:0] bus_data_in,  // Data seen by bus
  output logic      [15:0] data_pad_out, // Data pad values
  output logic      [15:0] data_pad_oe_n // Data pad enables
);
  // Control pin order: 0..3 cs0..cs3, 4 bs0, 5 bs1, 6 oe, 9:7 spare
  // Spare pins have no enable bit, so they always stay with GPIO.
  // Ownership takes two edges from the ownership register to the pads:
  // one into the select flops, one into the pad flops. The extra
  // edge is the price of a pad drive that never sees a select
  // glitch while the register or the disable pin changes.

  typedef struct packed {
    logic [31:0] own_ff;    // Ownership register
    logic [31:0] rdata_ff;  // Read data
    logic        dis_m_ff;  // Disable sync stage 1
    logic        dis_ff;    // Disable sync stage 2
    logic [9:0]  ctl_sel_ff;// Effective ctl ownership
    logic [1:0]  lane_sel_ff;// Effective lane ownership
  } ebpm_st_t;
  ebpm_st_t st_ff;
  ebpm_st_t nxt_st;
  logic [9:0] claim;
  logic [1:0] lane_claim;

  // Gate a claim by the module disable
  function automatic logic gate(input logic c, input logic d);
    gate = c & ~d;
  endfunction

  // Raw claims from the register
  always_comb
  begin
    claim = '0;
    claim[CS_HI_BIT-CS_LO_BIT:0] = st_ff.own_ff[CS_HI_BIT:CS_LO_BIT]; // [RULE_04]
    claim[4] = st_ff.own_ff[BS0_BIT]; // [RULE_03]
    claim[5] = st_ff.own_ff[BS1_BIT]; // [RULE_02]
    claim[6] = st_ff.own_ff[OE_BIT];  // [RULE_01]
    lane_claim[0] = st_ff.own_ff[LOD_BIT]; // [RULE_06]
    lane_claim[1] = st_ff.own_ff[UPD_BIT]; // [RULE_05]
  end

  // Next state
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.dis_m_ff = bus_module_disable;
    nxt_st.dis_ff   = st_ff.dis_m_ff;
    if (reg_wr && reg_addr == REG_OWNERSHIP_ADDR)
      nxt_st.own_ff = reg_wdata & OWNERSHIP_MASK; // [RULE_08]
    for (int i = 0; i < 10; i++)
      nxt_st.ctl_sel_ff[i] = gate(claim[i], st_ff.dis_ff); // [RULE_07]
    for (int i = 0; i < 2; i++)
      nxt_st.lane_sel_ff[i] = gate(lane_claim[i], st_ff.dis_ff); // [RULE_07]
    nxt_st.rdata_ff = '0; // Unmapped reads zero
    if (reg_rd)
    begin
      if (reg_addr == REG_OWNERSHIP_ADDR)
        nxt_st.rdata_ff = st_ff.own_ff;
      else if (reg_addr == REG_STATUS_ADDR)
        nxt_st.rdata_ff = {19'h0_0000, st_ff.dis_ff,
                           st_ff.lane_sel_ff, st_ff.ctl_sel_ff};
    end
    if (!rst_n)
    begin
      nxt_st = '0;
      nxt_st.own_ff = OWNERSHIP_RESET;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    st_ff <= nxt_st;
  end

  assign reg_rdata   = st_ff.rdata_ff;
  assign bus_data_in = data_pad_in; // Bus reads pads directly

  // Control pins, one mux per pin for glitch-free handover
  for (genvar g = 0; g < 10; g++)
  begin : g_ctl
    ebpm_pad_mux #(.W(1)) u_ctl (
      .clk      (clk),
      .rst_n    (rst_n),
      .sel_bus  (st_ff.ctl_sel_ff[g]), // [RULE_09]
      .bus_out  (bus_ctl_out[g]),
      .bus_oe_n (1'b0),
      .gp_out   (gp_ctl_out[g]),
      .gp_oe_n  (gp_ctl_oe_n[g]),
      .pad_out  (ctl_pad_out[g]),
      .pad_oe_n (ctl_pad_oe_n[g])
    );
  end

  // Data lanes
  for (genvar l = 0; l < 2; l++)
  begin : g_lane
    ebpm_pad_mux #(.W(LANE_W)) u_lane (
      .clk      (clk),
      .rst_n    (rst_n),
      .sel_bus  (st_ff.lane_sel_ff[l]), // [RULE_05] [RULE_06]
      .bus_out  (bus_data_out[l*LANE_W +: LANE_W]),
      .bus_oe_n ({LANE_W{bus_data_oe_n}}),
      .gp_out   (gp_data_out[l*LANE_W +: LANE_W]),
      .gp_oe_n  (gp_data_oe_n[l*LANE_W +: LANE_W]),
      .pad_out  (data_pad_out[l*LANE_W +: LANE_W]),
      .pad_oe_n (data_pad_oe_n[l*LANE_W +: LANE_W])
    );
  end

  // Checks
  unused_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_ff.own_ff & ~OWNERSHIP_MASK) == 32'h0) // [RULE_08]
    else $error("unimplemented bits set");
  disable_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff.dis_ff |=> (st_ff.ctl_sel_ff == 10'h000
                      && st_ff.lane_sel_ff == 2'h0)) // [RULE_07]
    else $error("pins kept while disabled");
  oe_claim_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!st_ff.dis_ff) |=> st_ff.ctl_sel_ff[6] == $past(st_ff.own_ff[OE_BIT]))
    else $error("oe ownership wrong"); // [RULE_01]
  bs1_claim_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!st_ff.dis_ff) |=> st_ff.ctl_sel_ff[5] == $past(st_ff.own_ff[BS1_BIT]))
    else $error("bs1 ownership wrong"); // [RULE_02]
  bs0_claim_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!st_ff.dis_ff) |=> st_ff.ctl_sel_ff[4] == $past(st_ff.own_ff[BS0_BIT]))
    else $error("bs0 ownership wrong"); // [RULE_03]
  cs_claim_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!st_ff.dis_ff) |=> st_ff.ctl_sel_ff[3:0] ==
      $past(st_ff.own_ff[CS_HI_BIT:CS_LO_BIT])) // [RULE_04]
    else $error("cs ownership wrong");
  upper_lane_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!st_ff.dis_ff) |=> st_ff.lane_sel_ff[1] == $past(st_ff.own_ff[UPD_BIT]))
    else $error("upper lane wrong"); // [RULE_05]
  lower_lane_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!st_ff.dis_ff) |=> st_ff.lane_sel_ff[0] == $past(st_ff.own_ff[LOD_BIT]))
    else $error("lower lane wrong"); // [RULE_06]
  pad_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff.lane_sel_ff[0] && $past(st_ff.lane_sel_ff[0])
    |=> data_pad_out[7:0] == $past(bus_data_out[7:0])) // [RULE_09]
    else $error("lane pad not driven by bus");
  wr_cov_c: cover property (@(posedge clk) reg_wr ##1 reg_rd);
  dis_cov_c: cover property (@(posedge clk) st_ff.dis_ff ##1 !st_ff.dis_ff);
  all_cov_c: cover property (@(posedge clk) st_ff.ctl_sel_ff[6:0] == 7'h7F);
  // Both data lanes handed to the bus at once
  lane_cov_c: cover property (@(posedge clk) st_ff.lane_sel_ff == 2'h3);
  // Software looks at the effective owners
  stat_cov_c: cover property (@(posedge clk)
    reg_rd && reg_addr == REG_STATUS_ADDR);

  // Register port checks
  // Read data stands one cycle only, then drops to zero
  rdata_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == 32'h0000_0000) // [RULE_08]
    else $error("read data not cleared");
  // A write to the ownership word lands masked on the next edge
  write_lands_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == REG_OWNERSHIP_ADDR) |=>
      st_ff.own_ff == ($past(reg_wdata) & OWNERSHIP_MASK)) // [RULE_08]
    else $error("ownership write lost");
  // Any other cycle leaves the ownership word alone
  write_ignored_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(reg_wr && reg_addr == REG_OWNERSHIP_ADDR) |=>
      $stable(st_ff.own_ff)) // [RULE_08]
    else $error("ownership changed without write");

  // Pin path checks
  // Spare control pins are never claimed by the bus
  spare_free_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff.ctl_sel_ff[9:7] == 3'h0) // [RULE_08]
    else $error("spare pin claimed");
  // The disable pin reaches logic through exactly two flops
  dis_sync_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff.dis_ff == $past(bus_module_disable, 2)) // [RULE_07]
    else $error("disable sync depth wrong");
  // A bus-owned output enable pin is always driven
  oe_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(st_ff.ctl_sel_ff[6]) |-> ctl_pad_oe_n[6] == 1'b0) // [RULE_01]
    else $error("oe pin not driven by bus");
endmodule

// ### sim/ebpm_pad_model.sv
// Model of the pads and general I/O logic around the pin mux.
// Assumes it sees the mux data pad outputs; the data pins have no pulls.
`timescale 1ns/1ps
module ebpm_pad_model (
  input  wire logic        clk,           // System clock
  output logic      [9:0]  gp_ctl_out,    // GPIO ctl values
  output logic      [9:0]  gp_ctl_oe_n,   // GPIO ctl enables
  output logic      [15:0] gp_data_out,   // GPIO data values
  output logic      [15:0] gp_data_oe_n,  // GPIO data enables
  input  wire logic [15:0] data_pad_out,  // Mux pad values
  input  wire logic [15:0] data_pad_oe_n, // Mux pad enables
  output logic      [15:0] data_pad_in    // Wire level seen
);
  integer      seed = 32'h0f30; // Fixed seed
  logic [31:0] r1, r2, r3;      // Random words
  logic [15:0] last = '0;       // Last wire level
  initial
  begin
    gp_ctl_out   = '0;
    gp_ctl_oe_n  = '1;
    gp_data_out  = '0;
    gp_data_oe_n = '1;
  end
  // Fresh GPIO drive each cycle, so a stale pad value cannot pass
  always @(posedge clk)
  begin
    r1 = $random(seed);
    r2 = $random(seed);
    r3 = $random(seed);
    gp_ctl_out   <= r1[9:0];
    gp_ctl_oe_n  <= r1[19:10];
    gp_data_out  <= r2[15:0];
    gp_data_oe_n <= r3[15:0];
  end
  // Released pins float: show the inverse of the last level
  always @(posedge clk) last <= data_pad_in;
  assign data_pad_in = (~data_pad_oe_n & data_pad_out) | (data_pad_oe_n & ~last);
endmodule

// ### sim/ebpm_top_tb.sv
// Self-checking bench for the external bus pin ownership mux.
// Assumes the pad model stands in for the GPIO logic and the pads.
`timescale 1ns/1ps
module ebpm_top_tb;
  import ebpm_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = '0;             // Register address
  logic [31:0] reg_wdata = '0, reg_rdata; // Register data
  logic        dis = 1'b0, bus_data_oe_n = 1'b1;  // Disable pin, bus oe
  logic [9:0]  bus_ctl_out = '0, gp_ctl_out, gp_ctl_oe_n, ctl_pad_out, ctl_pad_oe_n;
  logic [15:0] bus_data_out = '0, gp_data_out, gp_data_oe_n, data_pad_in;
  logic [15:0] bus_data_in, data_pad_out, data_pad_oe_n;
  logic [31:0] v, r;       // Written word, random word
  integer      seed = 32'h0f30, fail_count = 0, n_compared = 0;
  always #10 clk = ~clk;
  ebpm_top ebpm_top_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bus_module_disable(dis),
    .bus_ctl_out(bus_ctl_out), .gp_ctl_out(gp_ctl_out),
    .gp_ctl_oe_n(gp_ctl_oe_n), .ctl_pad_out(ctl_pad_out),
    .ctl_pad_oe_n(ctl_pad_oe_n), .bus_data_out(bus_data_out),
    .bus_data_oe_n(bus_data_oe_n), .gp_data_out(gp_data_out),
    .gp_data_oe_n(gp_data_oe_n), .data_pad_in(data_pad_in),
    .bus_data_in(bus_data_in), .data_pad_out(data_pad_out),
    .data_pad_oe_n(data_pad_oe_n));
  ebpm_pad_model ebpm_pad_model_inst (.clk(clk), .gp_ctl_out(gp_ctl_out),
    .gp_ctl_oe_n(gp_ctl_oe_n), .gp_data_out(gp_data_out),
    .gp_data_oe_n(gp_data_oe_n), .data_pad_out(data_pad_out),
    .data_pad_oe_n(data_pad_oe_n), .data_pad_in(data_pad_in));
  // Bus controller drive changes every cycle
  always @(posedge clk)
  begin
    r = $random(seed);
    bus_ctl_out   <= r[9:0];
    bus_data_out  <= r[25:10];
    bus_data_oe_n <= r[26];
  end
  // Owner bits: [9:0] ctl pins, [11:10] data lanes; disable clears all
  function automatic logic [11:0] exp_sel(logic [31:0] own, logic off);
    return off ? 12'h000 : {own[1:0], 3'h0, own[12], own[9:8], own[7:4]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (fail_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // One-cycle write strobe, entered just after an edge; the strobe is
  // left high after the edge and is dropped by the next rd task
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_rd    <= 1'b0;
    reg_wr    <= 1'b1;
    @(posedge clk);
  endtask
  // Read data is sampled at the edge after the taking edge
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    check(reg_rdata, exp);
  endtask
  // Pads registered: sources sampled at one edge show after it
  task automatic check_pads(input logic [11:0] s);
    logic [9:0]  bc, gc, ge;
    logic [15:0] bd, gd, go, ln;
    logic        bo;
    @(posedge clk);
    bc = bus_ctl_out;
    gc = gp_ctl_out;
    ge = gp_ctl_oe_n;
    bd = bus_data_out;
    gd = gp_data_out;
    go = gp_data_oe_n;
    bo = bus_data_oe_n;
    ln = {{8{s[11]}}, {8{s[10]}}};
    @(posedge clk);
    check(32'(ctl_pad_out), 32'((s[9:0] & bc) | (~s[9:0] & gc)));
    check(32'(ctl_pad_oe_n), 32'(~s[9:0] & ge));
    check(32'(data_pad_out), 32'((ln & bd) | (~ln & gd)));
    check(32'(data_pad_oe_n), 32'((ln & {16{bo}}) | (~ln & go)));
    check(32'(bus_data_in), 32'(data_pad_in));
  endtask
  // Watchdog: the run needs about 810 cycles
  initial
  begin
    #200000;
    fail_count++;
    print_verdict;
  end
  // Main sequence: corners first, then random words and disable
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(REG_OWNERSHIP_ADDR, OWNERSHIP_RESET);
    for (int i = 0; i < 40; i++)
    begin
      v = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0000_0000 : $random(seed);
      wr(REG_OWNERSHIP_ADDR, v);
      wr(REG_STATUS_ADDR, ~v);
      rd(REG_OWNERSHIP_ADDR, v & OWNERSHIP_MASK);
      rd(8'h3C, 32'h0000_0000);
      dis <= (i > 3) && v[20];
      repeat (6) @(posedge clk);
      rd(REG_STATUS_ADDR, {19'h0, dis, exp_sel(v, dis)});
      repeat (3) check_pads(exp_sel(v, dis));
    end
    print_verdict;
  end
endmodule
